// File: hw/scr_cfg.svh
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH
`define SCR_ADDR_W 7
`define SCR_OFF_LOCK_CORE 7'h6E
`define SCR_OFF_CAPBAND 7'h6F
`define SCR_OFF_AMPL 7'h70
`define SCR_OFF_IRQ_STATUS 7'h71
`define SCR_OFF_IRQ_MASK 7'h72
`define SCR_LOCK_LSB 9
`define SCR_CORE_LSB 5
`define SCR_CAPBAND_RST 8'hB7
`define SCR_CAPBAND_MAX 8'hB7
`define SCR_AMPL_RST 9'h0AA
`define SCR_LOCK_RST 2'h0
`define SCR_CORE_RST 3'h0
`define SCR_DBLR_BIAS_NEW 16'h0C2B
`define SCR_DBLR_BIAS_OLD 16'h0624
`define SCR_OUT_PWR_TYP 8'h32
`define SCR_IRQ_LOCK_GAINED 0
`define SCR_IRQ_LOCK_LOST 1
`define SCR_IRQ_CAL_DONE 2
`define SCR_IRQ_W 3
`endif

// File: hw/scr_pkg.sv
package scr_pkg;
  typedef enum logic [1:0]
  {
    SCR_UNLOCK_LOW = 2'h0,
    SCR_INVALID = 2'h1,
    SCR_LOCKED = 2'h2,
    SCR_UNLOCK_HIGH = 2'h3
  } scr_lock_t;
endpackage

// File: hw/scr_sync.sv
`timescale 1ns/1ns
`default_nettype none
`include "scr_cfg.svh"
module scr_sync #(
  parameter int W = 2
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } scr_sync_t;
  scr_sync_t st_q;
  scr_sync_t st_d;
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // accept a change once the last two stages agree
    if (st_q.s2 == st_q.s3)
    begin
      st_d.lvl = st_q.s3;
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
  assign level_o = st_q.lvl;
endmodule
`default_nettype wire

// File: hw/scr_readback.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "scr_cfg.svh"
module scr_readback
  import scr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [`SCR_ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [1:0] tune_voltage_lock_state_i,
  input wire logic cal_done_i,
  input wire logic [2:0] selected_oscillator_core_i,
  input wire logic [7:0] chosen_capacitor_band_code_i,
  input wire logic [8:0] chosen_amplitude_setting_i,
  output logic irq_o
);
  typedef struct packed
  {
    logic [1:0] lock;
    logic [2:0] core;
    logic [7:0] capband;
    logic [8:0] ampl;
    logic [`SCR_IRQ_W-1:0] irq_st;
    logic [`SCR_IRQ_W-1:0] irq_mask;
    logic [15:0] rdata;
  } scr_state_t;
  scr_state_t st_q;
  scr_state_t st_d;
  logic [1:0] lock_sync;
  logic [`SCR_IRQ_W-1:0] ev;
  scr_sync #(
    .W(2)
  ) u_lock_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(tune_voltage_lock_state_i),
    .level_o(lock_sync)
  );
  always_comb
  begin
    st_d = st_q;
    ev = '0;
    st_d.lock = lock_sync;
    ev[`SCR_IRQ_LOCK_GAINED] = (lock_sync == SCR_LOCKED) && (st_q.lock != SCR_LOCKED);
    ev[`SCR_IRQ_LOCK_LOST] = (lock_sync != SCR_LOCKED) && (st_q.lock == SCR_LOCKED);
    ev[`SCR_IRQ_CAL_DONE] = cal_done_i;
    if (cal_done_i)
    begin
      st_d.core = selected_oscillator_core_i;
      if (chosen_capacitor_band_code_i > `SCR_CAPBAND_MAX)
      begin
        st_d.capband = `SCR_CAPBAND_MAX;
      end
      else
      begin
        st_d.capband = chosen_capacitor_band_code_i;
      end
      st_d.ampl = chosen_amplitude_setting_i;
    end
    // writes reach only the interrupt registers
    if (wr_i && addr_i == `SCR_OFF_IRQ_MASK)
    begin
      st_d.irq_mask = wdata_i[`SCR_IRQ_W-1:0];
    end
    if (wr_i && addr_i == `SCR_OFF_IRQ_STATUS)
    begin
      st_d.irq_st = st_q.irq_st & ~wdata_i[`SCR_IRQ_W-1:0];
    end
    // set wins over clear
    st_d.irq_st = st_d.irq_st | ev;
    st_d.rdata = '0;
    if (rd_i)
    begin
      unique case (addr_i)
        `SCR_OFF_LOCK_CORE:
        begin
          st_d.rdata[`SCR_LOCK_LSB+:2] = st_q.lock;
          st_d.rdata[`SCR_CORE_LSB+:3] = st_q.core;
        end
        `SCR_OFF_CAPBAND:
        begin
          st_d.rdata[7:0] = st_q.capband;
        end
        `SCR_OFF_AMPL:
        begin
          st_d.rdata[8:0] = st_q.ampl;
        end
        `SCR_OFF_IRQ_STATUS:
        begin
          st_d.rdata[`SCR_IRQ_W-1:0] = st_q.irq_st;
        end
        `SCR_OFF_IRQ_MASK:
        begin
          st_d.rdata[`SCR_IRQ_W-1:0] = st_q.irq_mask;
        end
        default:
        begin
          st_d.rdata = '0;
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_q.lock <= `SCR_LOCK_RST;
      st_q.core <= `SCR_CORE_RST;
      st_q.capband <= `SCR_CAPBAND_RST;
      st_q.ampl <= `SCR_AMPL_RST;
      st_q.irq_st <= '0;
      st_q.irq_mask <= '0;
      st_q.rdata <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
  assign rdata_o = st_q.rdata;
  assign irq_o = |(st_q.irq_st & st_q.irq_mask);
endmodule
`default_nettype wire

// File: verification/scr_rb_properties.sv
`timescale 1ns/1ns
`default_nettype none
module scr_rb_properties
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [6:0] addr_i,
  input wire logic rd_i,
  input wire logic cal_done_i,
  input wire logic [7:0] chosen_capacitor_band_code_i,
  input wire logic [8:0] chosen_amplitude_setting_i,
  input wire logic [15:0] rdata_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence cal_rd(a);
    cal_done_i ##1 (rd_i && !cal_done_i && addr_i == a);
  endsequence
  chk_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("idle data");
  chk_band_limit: assert property ($past(rd_i) && $past(addr_i) == 7'h6F |-> rdata_o <= 16'h00B7)
    else $error("band range");
  chk_ampl_pad: assert property ($past(rd_i) && $past(addr_i) == 7'h70 |-> rdata_o[15:9] == 7'h00)
    else $error("ampl pad");
  chk_lock_pad: assert property ($past(rd_i) && $past(addr_i) == 7'h6E
    |-> {rdata_o[15:11], rdata_o[8], rdata_o[4:0]} == 11'h000)
    else $error("lock pad");
  chk_cal_band: assert property (cal_rd(7'h6F) |=> rdata_o[7:0] == $past(chosen_capacitor_band_code_i, 2)
    || $past(chosen_capacitor_band_code_i, 2) > 8'hB7)
    else $error("band capture");
  chk_cal_ampl: assert property (cal_rd(7'h70) |=> rdata_o[8:0] == $past(chosen_amplitude_setting_i, 2))
    else $error("ampl capture");
endmodule
bind scr_readback scr_rb_properties i_chk (.clk_sys_i, .rst_i, .addr_i, .rd_i, .cal_done_i,
  .chosen_capacitor_band_code_i, .chosen_amplitude_setting_i, .rdata_o);
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, cal_done_i = 0, irq_o;
  logic [6:0] addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o, lf = 16'h005B;
  logic [1:0] lk = 0;
  logic [2:0] co = 0;
  logic [7:0] bd = 0;
  logic [8:0] am = 0;
  int n_mismatch = 0, cmp_count = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  scr_readback i_dut (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .tune_voltage_lock_state_i(lk), .cal_done_i, .selected_oscillator_core_i(co),
    .chosen_capacitor_band_code_i(bd), .chosen_amplitude_setting_i(am), .irq_o);
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] clamp(input logic [7:0] b);
    return (b > 8'hB7) ? 8'hB7 : b;
  endfunction
  task chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task rc(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    rd_i <= 1;
    cal_done_i <= 0;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 0;
    #1 chk("rdata", e, rdata_o);
  endtask
  task wr(input logic [6:0] a, input logic [15:0] d, input logic q);
    @(posedge clk_sys_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 0;
    #1 chk("irq", {15'h0000, q}, {15'h0000, irq_o});
  endtask
  task final_report;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    n_mismatch++;
    final_report;
  end
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 0;
    rc(7'h6E, 16'h0000);
    rc(7'h6F, 16'h00B7);
    rc(7'h70, 16'h00AA);
    wr(7'h6F, 16'h0012, 0);
    rc(7'h6F, 16'h00B7);
    rc(7'h73, 16'h0000);
    // doubler bias and output power words live outside this bank
    wr(7'h19, 16'h0C2B, 0);
    wr(7'h2C, 16'h0032, 0);
    rc(7'h19, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      lf = lfsr_next(lf);
      @(posedge clk_sys_i);
      cal_done_i <= 1;
      co <= lf[2:0];
      bd <= (i == 0) ? 8'hFF : lf[10:3];
      am <= lf[15:7];
      // the read strobe follows the calibration pulse directly
      if (i % 2 == 1)
      begin
        rc(7'h70, {7'h00, lf[15:7]});
        rc(7'h6F, {8'h00, clamp(lf[10:3])});
      end
      else
      begin
        rc(7'h6F, {8'h00, clamp((i == 0) ? 8'hFF : lf[10:3])});
        rc(7'h70, {7'h00, lf[15:7]});
      end
    end
    wr(7'h72, 16'h0000, 0);
    wr(7'h72, 16'h0004, 1);
    wr(7'h71, 16'h0004, 0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys_i);
      lk <= i[1:0];
      repeat (8) @(posedge clk_sys_i);
      rc(7'h6E, {5'h00, i[1:0], 1'b0, lf[2:0], 5'h00});
    end
    final_report;
  end
endmodule
`default_nettype wire
